//--- uar_pkg.sv
/*
 * Shared constants and types for the ASCII command responder.
 * Assumes one 25 MHz system clock and a 9600 bps serial link.
 */
package uar_pkg;

    // System clock rate and link rate in hertz and bits per second.
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned LINK_BPS = 9600;
    // Clock cycles in one bit time, rounded down.
    localparam int unsigned BIT_CYCLES = CLK_HZ / LINK_BPS;
    // Clock cycles from a start edge to the middle of the start bit.
    localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;

    // Frame layout: data bits per character.
    localparam int unsigned DATA_BITS = 8;
    // Ring depth in entries and entry width in bits.
    localparam int unsigned RING_DEPTH = 16;
    localparam int unsigned RING_WIDTH = 8;
    // Characters in every response message.
    localparam logic [7:0] MSG_LEN = 8'h04;

    // Received characters that are recognised.
    localparam logic [7:0] CHR_UPPER_T = 8'h54;
    localparam logic [7:0] CHR_LOWER_T = 8'h74;
    // Response characters.
    localparam logic [7:0] CHR_O = 8'h4F;
    localparam logic [7:0] CHR_K = 8'h4B;
    localparam logic [7:0] CHR_LO = 8'h6F;
    localparam logic [7:0] CHR_LK = 8'h6B;
    localparam logic [7:0] CHR_U = 8'h55;
    localparam logic [7:0] CHR_C = 8'h43;
    localparam logic [7:0] CHR_P = 8'h50;
    localparam logic [7:0] CHR_F = 8'h46;
    localparam logic [7:0] CHR_E = 8'h45;
    localparam logic [7:0] CHR_CR = 8'h0D;
    localparam logic [7:0] CHR_LF = 8'h0A;

    // Ring record layout: bit 7 marks an error record.
    localparam int unsigned REC_ERR_BIT = 7;
    // Error record bits: parity, framing and overrun.
    localparam int unsigned REC_PE_BIT = 0;
    localparam int unsigned REC_FE_BIT = 1;
    localparam int unsigned REC_OE_BIT = 2;

    // Message identifiers, also the record value of a character response.
    typedef enum logic [2:0] {
        UAR_MSG_UPPER_ACK,
        UAR_MSG_LOWER_ACK,
        UAR_MSG_UNKNOWN,
        UAR_MSG_PARITY_ERR,
        UAR_MSG_FRAMING_ERR,
        UAR_MSG_OVERRUN_ERR
    } uar_msg_e;

    // One completed reception with its error status.
    typedef struct packed {
        logic [7:0] data;
        logic overrun_err;
        logic framing_err;
        logic parity_err;
    } uar_rx_evt_s;

endpackage

//--- uar_ring_mem.sv
/*
 * Small synchronous memory that holds the response ring entries.
 * Assumes the owner keeps the pointers; read data come from a register.
 */
`timescale 1ns/100ps

module uar_ring_mem #(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_ff
);

    // Storage array; its contents need no reset.
    logic [WIDTH-1:0] mem [DEPTH];

    // Writes land at the end of the cycle that asks for them.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data appear one cycle after the request.
    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data_ff <= mem[rd_addr];
        end
    end

endmodule

//--- uar_responder.sv
/*
 * ASCII command responder: serial receiver, response ring and sender.
 * Assumes a 25 MHz clock, a synchronous active-high reset, and an
 * asynchronous serial line that is resynchronised here.
 */
// How it works
// (RULE_01) Sixteen byte ring, separate read/write pointers.
// (RULE_02) Fill count follows every store and read.
// (RULE_03) T answers O, K, CR, LF.
// (RULE_04) t answers o, k, CR, LF.
// (RULE_05) Other characters answer U, C, CR, LF.
// (RULE_06) Framing error answers F, E, CR, LF.
// (RULE_07) Parity error answers P, E, CR, LF.
// (RULE_08) Overrun answers O, E, CR, LF.
// (RULE_09) Store only with room; report full.
// (RULE_10) Read returns oldest entry, else nothing.
// (RULE_11) Received byte classified, queued, dropped when full.
// (RULE_12) Error cancels reception, queues status when room.
// (RULE_13) Error record expands into message when sent.
// (RULE_14) Each byte end decrements counter, then masks.
// (RULE_15) Eight bit byte counter, zero means done.
// (RULE_16) Four characters per message before next fetch.
// (RULE_17) Enable starts both channels, events unmasked.
// (RULE_18) Eight bits, LSB first, even parity, 9600.
// (RULE_19) Idle checks ring, sends oldest, checks again.
// (RULE_20) Pointers wrap to zero, stored order kept.
// (RULE_21) Reception continues during transmission.
`timescale 1ns/100ps

module uar_responder
    import uar_pkg::*;
#(
    parameter int unsigned DEPTH = RING_DEPTH,
    // Clock cycles in one bit time.
    parameter int unsigned BIT_LEN = BIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_enable,
    input wire logic serial_rx_pin,
    output logic serial_tx_pin_ff,
    output logic store_refused_ff,
    output logic sender_busy_ff
);

    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [15:0] BIT_CNT_MAX = 16'(BIT_LEN - 1);
    localparam logic [15:0] HALF_CNT_MAX = 16'(BIT_LEN / 2 - 1);
    localparam logic [7:0] DEPTH_B = 8'(DEPTH);
    localparam logic [7:0] LAST_IDX = 8'(DEPTH - 1);

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} uar_rx_state_e;
    typedef enum {TX_IDLE, TX_FETCH, TX_DECODE, TX_PICK, TX_START, TX_SEND} uar_snd_state_e;

    // Character of a message at a given position.
    function automatic logic [7:0] msg_byte(input uar_msg_e id, input logic [1:0] idx);
        logic [7:0] c0;
        logic [7:0] c1;
        c0 = CHR_U;
        c1 = CHR_C;
        case (id)
            // (RULE_03) Upper acknowledge text.
            UAR_MSG_UPPER_ACK: begin c0 = CHR_O; c1 = CHR_K; end
            // (RULE_04) Lower acknowledge text.
            UAR_MSG_LOWER_ACK: begin c0 = CHR_LO; c1 = CHR_LK; end
            // (RULE_07) Parity error text.
            UAR_MSG_PARITY_ERR: begin c0 = CHR_P; c1 = CHR_E; end
            // (RULE_06) Framing error text.
            UAR_MSG_FRAMING_ERR: begin c0 = CHR_F; c1 = CHR_E; end
            // (RULE_08) Overrun error text.
            UAR_MSG_OVERRUN_ERR: begin c0 = CHR_O; c1 = CHR_E; end
            // (RULE_05) Unknown character text.
            default: begin c0 = CHR_U; c1 = CHR_C; end
        endcase
        case (idx)
            2'h0: msg_byte = c0;
            2'h1: msg_byte = c1;
            2'h2: msg_byte = CHR_CR;
            default: msg_byte = CHR_LF;
        endcase
    endfunction

    // Ring pointer advance with wrap to entry zero.
    function automatic logic [7:0] ptr_next(input logic [7:0] p);
        ptr_next = (p == LAST_IDX) ? 8'h00 : p + 8'h01;
    endfunction

    logic rx_meta_ff;                 // First synchroniser stage.
    logic rx_sync_ff;                 // Second synchroniser stage.
    logic rx_prev_ff;                 // Previous synchronised level.
    uar_rx_state_e rx_state_ff;       // Receiver state.
    logic [15:0] rx_baud_ff;          // Receiver bit timer.
    logic [2:0] rx_bit_ff;            // Data bit index.
    logic [7:0] rx_shift_ff;          // Data being assembled.
    logic rx_par_err_ff;              // Parity mismatch of current frame.
    uar_rx_evt_s rx_evt_ff;           // Last completed frame.
    logic rx_evt_valid_ff;            // Frame waiting for classification.
    logic [7:0] ring_write_ptr;       // Next entry to fill.
    logic [7:0] ring_read_ptr;        // Oldest entry.
    logic [7:0] ring_fill_count;      // Entries held.
    logic [7:0] ring_rd_data;         // Fetched entry.
    logic ring_store;                 // Store strobe this cycle.
    logic ring_fetch;                 // Fetch strobe this cycle.
    logic ring_full;                  // Store would be refused.
    logic [7:0] store_rec;            // Record to store.
    uar_snd_state_e snd_state_ff;     // Sender state.
    logic [7:0] rec_ff;               // Record being sent.
    logic [2:0] err_left_ff;          // Error messages still to send.
    uar_msg_e msg_ff;                 // Message being sent.
    logic [7:0] tx_bytes_left;        // Characters left in message.
    logic [1:0] tx_idx_ff;            // Position of current character.
    logic tx_done_mask_ff;            // Byte-end events ignored when set.
    logic tx_start;                   // Begin one character.
    logic [10:0] tx_shift_ff;         // Serial frame shifting out.
    logic [3:0] tx_bits_ff;           // Frame bits still to send.
    logic [15:0] tx_baud_ff;          // Transmitter bit timer.
    logic tx_done_event;              // One character has left the pin.

    // Two-stage synchroniser and edge history for the receive pin.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
            rx_prev_ff <= 1'b1;
        end else begin
            rx_meta_ff <= serial_rx_pin;
            rx_sync_ff <= rx_meta_ff;
            rx_prev_ff <= rx_sync_ff;
        end
    end

    // Receiver frame sequencer, sampling each bit at its middle.
    always_ff @(posedge clk) begin
        if (rst || !link_enable) begin
            rx_state_ff <= RX_IDLE;
            rx_baud_ff <= 16'h0000;
            rx_bit_ff <= 3'h0;
            rx_shift_ff <= 8'h00;
            rx_par_err_ff <= 1'b0;
        end else begin
            case (rx_state_ff)
                // (RULE_17) Wait for a start edge while enabled.
                RX_IDLE: begin
                    if (rx_prev_ff && !rx_sync_ff) begin
                        rx_state_ff <= RX_START;
                        rx_baud_ff <= HALF_CNT_MAX;
                    end
                end
                // A start bit that is not low at its middle is a glitch.
                RX_START: begin
                    if (rx_baud_ff != 16'h0000) begin
                        rx_baud_ff <= rx_baud_ff - 16'h0001;
                    end else if (rx_sync_ff) begin
                        rx_state_ff <= RX_IDLE;
                    end else begin
                        rx_state_ff <= RX_DATA;
                        rx_baud_ff <= BIT_CNT_MAX;
                        rx_bit_ff <= 3'h0;
                    end
                end
                // (RULE_18) Data arrive least significant bit first.
                RX_DATA: begin
                    if (rx_baud_ff != 16'h0000) begin
                        rx_baud_ff <= rx_baud_ff - 16'h0001;
                    end else begin
                        rx_shift_ff <= {rx_sync_ff, rx_shift_ff[7:1]};
                        rx_baud_ff <= BIT_CNT_MAX;
                        rx_bit_ff <= rx_bit_ff + 3'h1;
                        if (rx_bit_ff == 3'(DATA_BITS - 1)) begin
                            rx_state_ff <= RX_PARITY;
                        end
                    end
                end
                // (RULE_18) Even parity over data and parity bit.
                RX_PARITY: begin
                    if (rx_baud_ff != 16'h0000) begin
                        rx_baud_ff <= rx_baud_ff - 16'h0001;
                    end else begin
                        rx_par_err_ff <= (^rx_shift_ff) ^ rx_sync_ff;
                        rx_baud_ff <= BIT_CNT_MAX;
                        rx_state_ff <= RX_STOP;
                    end
                end
                // Stop bit sampled; the frame ends here.
                RX_STOP: begin
                    if (rx_baud_ff != 16'h0000) begin
                        rx_baud_ff <= rx_baud_ff - 16'h0001;
                    end else begin
                        rx_state_ff <= RX_IDLE;
                    end
                end
                default: rx_state_ff <= RX_IDLE;
            endcase
        end
    end

    // Completed frame handed to the classifier, with its error status.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_evt_ff <= '0;
            rx_evt_valid_ff <= 1'b0;
        end else if (rx_state_ff == RX_STOP && rx_baud_ff == 16'h0000) begin
            rx_evt_ff.data <= rx_shift_ff;
            rx_evt_ff.parity_err <= rx_par_err_ff;
            rx_evt_ff.framing_err <= !rx_sync_ff;
            // (RULE_08) Frame completes before the previous was taken.
            rx_evt_ff.overrun_err <= rx_evt_valid_ff;
            rx_evt_valid_ff <= 1'b1;
        end else begin
            rx_evt_valid_ff <= 1'b0;
        end
    end

    // (RULE_11) Classify a good byte into its response record.
    always_comb begin
        if (rx_evt_ff.parity_err || rx_evt_ff.framing_err || rx_evt_ff.overrun_err) begin
            // (RULE_12) An error replaces the receive-complete request.
            store_rec = 8'h00;
            store_rec[REC_ERR_BIT] = 1'b1;
            store_rec[REC_PE_BIT] = rx_evt_ff.parity_err;
            store_rec[REC_FE_BIT] = rx_evt_ff.framing_err;
            store_rec[REC_OE_BIT] = rx_evt_ff.overrun_err;
        end else if (rx_evt_ff.data == CHR_UPPER_T) begin
            store_rec = {5'h00, UAR_MSG_UPPER_ACK};
        end else if (rx_evt_ff.data == CHR_LOWER_T) begin
            store_rec = {5'h00, UAR_MSG_LOWER_ACK};
        end else begin
            store_rec = {5'h00, UAR_MSG_UNKNOWN};
        end
    end

    // (RULE_09) Store only when the ring has room.
    // A fetch in the same cycle frees an entry, so the store has room.
    assign ring_full = (ring_fill_count == DEPTH_B) && !ring_fetch;
    // (RULE_21) Stores proceed in any sender state, except on a full ring, where only a fetch by the idle sender lets them in.
    assign ring_store = rx_evt_valid_ff && !ring_full;
    // (RULE_19) Fetch the oldest record when idle and not empty.
    assign ring_fetch = (snd_state_ff == TX_IDLE) && link_enable && (ring_fill_count != 8'h00);

    // (RULE_09) Refused store is reported for one cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            store_refused_ff <= 1'b0;
        end else begin
            store_refused_ff <= rx_evt_valid_ff && ring_full;
        end
    end

    // (RULE_20) Pointers advance and wrap to entry zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            ring_write_ptr <= 8'h00;
            ring_read_ptr <= 8'h00;
        end else begin
            if (ring_store) begin
                ring_write_ptr <= ptr_next(ring_write_ptr);
            end
            if (ring_fetch) begin
                ring_read_ptr <= ptr_next(ring_read_ptr);
            end
        end
    end

    // (RULE_02) Fill count tracks stores and fetches together.
    always_ff @(posedge clk) begin
        if (rst) begin
            ring_fill_count <= 8'h00;
        end else if (ring_store && !ring_fetch) begin
            ring_fill_count <= ring_fill_count + 8'h01;
        end else if (ring_fetch && !ring_store) begin
            ring_fill_count <= ring_fill_count - 8'h01;
        end
    end

    // (RULE_01) Sixteen entries of eight bits.
    uar_ring_mem #(
        .DEPTH(DEPTH),
        .WIDTH(RING_WIDTH)
    ) u_ring (
        .clk(clk),
        .wr_en(ring_store),
        .wr_addr(ring_write_ptr[AW-1:0]),
        .wr_data(store_rec),
        .rd_en(ring_fetch),
        .rd_addr(ring_read_ptr[AW-1:0]),
        .rd_data_ff(ring_rd_data)
    );

    // Message sequencer: one record becomes one or more messages.
    always_ff @(posedge clk) begin
        if (rst) begin
            snd_state_ff <= TX_IDLE;
            rec_ff <= 8'h00;
            err_left_ff <= 3'h0;
            msg_ff <= UAR_MSG_UNKNOWN;
        end else begin
            case (snd_state_ff)
                // (RULE_10) Only a non-empty ring yields a record.
                TX_IDLE: begin
                    if (ring_fetch) begin
                        snd_state_ff <= TX_FETCH;
                    end
                end
                // Memory read data arrive in the next cycle.
                TX_FETCH: snd_state_ff <= TX_DECODE;
                TX_DECODE: begin
                    rec_ff <= ring_rd_data;
                    if (ring_rd_data[REC_ERR_BIT]) begin
                        err_left_ff <= ring_rd_data[2:0];
                        snd_state_ff <= TX_PICK;
                    end else begin
                        msg_ff <= uar_msg_e'(ring_rd_data[2:0]);
                        snd_state_ff <= TX_START;
                    end
                end
                // (RULE_13) Each set error bit becomes its message.
                TX_PICK: begin
                    if (err_left_ff[REC_PE_BIT]) begin
                        msg_ff <= UAR_MSG_PARITY_ERR;
                        err_left_ff[REC_PE_BIT] <= 1'b0;
                        snd_state_ff <= TX_START;
                    end else if (err_left_ff[REC_FE_BIT]) begin
                        msg_ff <= UAR_MSG_FRAMING_ERR;
                        err_left_ff[REC_FE_BIT] <= 1'b0;
                        snd_state_ff <= TX_START;
                    end else if (err_left_ff[REC_OE_BIT]) begin
                        msg_ff <= UAR_MSG_OVERRUN_ERR;
                        err_left_ff[REC_OE_BIT] <= 1'b0;
                        snd_state_ff <= TX_START;
                    end else begin
                        snd_state_ff <= TX_IDLE;
                    end
                end
                TX_START: snd_state_ff <= TX_SEND;
                // (RULE_16) Leave only after the fourth character ends.
                TX_SEND: begin
                    if (tx_done_event && !tx_done_mask_ff && tx_bytes_left == 8'h01) begin
                        snd_state_ff <= rec_ff[REC_ERR_BIT] ? TX_PICK : TX_IDLE;
                    end
                end
                default: snd_state_ff <= TX_IDLE;
            endcase
        end
    end

    // (RULE_14) Byte counter, character index and completion mask.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_bytes_left <= 8'h00;
            tx_idx_ff <= 2'h0;
            tx_done_mask_ff <= 1'b1;
        end else if (snd_state_ff == TX_START) begin
            tx_bytes_left <= MSG_LEN;
            tx_idx_ff <= 2'h0;
            tx_done_mask_ff <= 1'b0;
        end else if (tx_done_event && !tx_done_mask_ff) begin
            // (RULE_15) Zero marks the message as fully sent.
            tx_bytes_left <= tx_bytes_left - 8'h01;
            tx_idx_ff <= tx_idx_ff + 2'h1;
            tx_done_mask_ff <= (tx_bytes_left == 8'h01);
        end
    end

    // (RULE_14) Next character starts while characters remain.
    assign tx_start = (snd_state_ff == TX_START) ||
        (tx_done_event && !tx_done_mask_ff && tx_bytes_left != 8'h01);

    // (RULE_18) Frame: start, data LSB first, even parity, stop.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_shift_ff <= 11'h7FF;
            tx_bits_ff <= 4'h0;
            tx_baud_ff <= 16'h0000;
            serial_tx_pin_ff <= 1'b1;
        end else if (tx_start) begin
            tx_shift_ff <= {1'b1, ^msg_byte(msg_ff, tx_idx_ff + 2'(tx_done_event)),
                msg_byte(msg_ff, tx_idx_ff + 2'(tx_done_event)), 1'b0};
            tx_bits_ff <= 4'hB;
            tx_baud_ff <= 16'h0000;
        end else if (tx_bits_ff != 4'h0) begin
            if (tx_baud_ff == 16'h0000) begin
                serial_tx_pin_ff <= tx_shift_ff[0];
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                tx_bits_ff <= tx_bits_ff - 4'h1;
                tx_baud_ff <= BIT_CNT_MAX;
            end else begin
                tx_baud_ff <= tx_baud_ff - 16'h0001;
            end
        end else if (tx_baud_ff != 16'h0000) begin
            tx_baud_ff <= tx_baud_ff - 16'h0001;
        end
    end

    // End of stop bit is the byte-complete event.
    assign tx_done_event = (tx_bits_ff == 4'h0) && (tx_baud_ff == 16'h0001);

    // Busy flag for the surroundings while a record is in hand.
    always_ff @(posedge clk) begin
        if (rst) begin
            sender_busy_ff <= 1'b0;
        end else begin
            sender_busy_ff <= (snd_state_ff != TX_IDLE);
        end
    end

endmodule

//--- uar_responder_props.sv
/* Checker for the responder ports: serial output timing, busy and refusal flags.
   Assumes it is bound to uar_responder and sees only its ports. */
`timescale 1ns/100ps
module uar_responder_props
    import uar_pkg::*;
#(
    parameter int unsigned DEPTH = RING_DEPTH,
    // Clock cycles in one bit time.
    parameter int unsigned BIT_LEN = BIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_enable,
    input wire logic serial_rx_pin,
    input wire logic serial_tx_pin_ff,
    input wire logic store_refused_ff,
    input wire logic sender_busy_ff
);
    // Length of the current low run on the output, in cycles.
    int unsigned low_run_ff;
    // Length of the current busy spell, in cycles.
    int unsigned busy_run_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Counts cycles while the output is low.
    always_ff @(posedge clk) begin
        low_run_ff <= (rst || serial_tx_pin_ff) ? 0 : low_run_ff + 1;
    end
    // Counts cycles while the sender is busy.
    always_ff @(posedge clk) begin
        busy_run_ff <= (rst || !sender_busy_ff) ? 0 : busy_run_ff + 1;
    end
    // The sender has just taken a message.
    sequence s_msg_start;
        $rose(sender_busy_ff);
    endsequence
    property p_release;
        $fell(rst) |-> serial_tx_pin_ff && !sender_busy_ff && !store_refused_ff;
    endproperty
    property p_refuse_pulse;
        store_refused_ff |=> !store_refused_ff [*8];
    endproperty
    property p_refuse_busy;
        store_refused_ff |-> sender_busy_ff;
    endproperty
    property p_start_bit;
        s_msg_start |-> ##[1:8] !serial_tx_pin_ff;
    endproperty
    property p_busy_holds;
        s_msg_start |=> sender_busy_ff [*8];
    endproperty
    property p_fall_busy;
        $fell(serial_tx_pin_ff) |-> sender_busy_ff;
    endproperty
    property p_idle_high;
        !sender_busy_ff [*3] |-> serial_tx_pin_ff;
    endproperty
    property p_bit_time;
        $rose(serial_tx_pin_ff) |-> low_run_ff != 0 && low_run_ff % BIT_LEN == 0;
    endproperty
    property p_four_chars;
        $fell(sender_busy_ff) |-> busy_run_ff >= 43 * BIT_LEN;
    endproperty
    a_release: assert property (p_release) else $error("idle state wrong");
    a_refuse_pulse: assert property (p_refuse_pulse) else $error("refusal too long");
    a_refuse_busy: assert property (p_refuse_busy) else $error("refused while idle");
    a_start_bit: assert property (p_start_bit) else $error("no start bit");
    a_busy_holds: assert property (p_busy_holds) else $error("busy dropped");
    a_fall_busy: assert property (p_fall_busy) else $error("output fell idle");
    a_idle_high: assert property (p_idle_high) else $error("output low idle");
    a_bit_time: assert property (p_bit_time) else $error("bit time wrong");
    a_four_chars: assert property (p_four_chars) else $error("message short");
endmodule
bind uar_responder uar_responder_props #(.DEPTH(DEPTH), .BIT_LEN(BIT_LEN)) u_props (
    .clk(clk), .rst(rst),
    .link_enable(link_enable), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin_ff(serial_tx_pin_ff), .store_refused_ff(store_refused_ff),
    .sender_busy_ff(sender_busy_ff));

//--- uar_remote_dev.sv
/* Remote serial device: sends frames to the responder and decodes its answers.
   Assumes the bench clock and the package bit time. */
`timescale 1ns/100ps
module uar_remote_dev
    import uar_pkg::*;
#(
    parameter int unsigned BIT_LEN = BIT_CYCLES
) (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    // Decoded answer characters, oldest first.
    logic [7:0] got_q[$];
    // Answer frames with a bad start, parity or stop bit.
    int line_faults = 0;
    // Bits of the frame being decoded.
    logic [10:0] frm;
    initial line_out = 1'b1;
    // Sends one frame, optionally with a bad parity or stop bit.
    // frame format out
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic [10:0] f;
        f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_out <= f[i];
            repeat (BIT_LEN) @(posedge clk);
        end
        line_out <= 1'b1;
        repeat (BIT_LEN / 4) @(posedge clk);
    endtask
    // Decodes each answer frame, sampling in the middle of each bit.
    // frame format in
    initial begin
        forever begin
            @(negedge line_in);
            repeat (BIT_LEN / 2) @(posedge clk);
            for (int i = 0; i < 11; i++) begin
                frm[i] = line_in;
                if (i < 10) repeat (BIT_LEN) @(posedge clk);
            end
            if (frm[0] || !frm[10] || ^frm[9:1]) line_faults++;
            got_q.push_back(frm[8:1]);
        end
    end
endmodule

//--- uart_ascii_responder_bench.sv
/* Testbench for the responder: frames go in, answers are compared with a queue model.
   Assumes the remote device model and the bound checker. */
`timescale 1ns/100ps
module uart_ascii_responder_bench
    import uar_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic link_enable = 1'b0;
    logic line_to_dut;
    logic tx_pin;
    logic refused;
    logic busy;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int refusals = 0;
    // Short bit time keeps the run brief.
    localparam int unsigned BL = 32;
    // Expected answer characters, in order.
    logic [7:0] exp_q[$];
    always #20 clk = ~clk;
    uar_responder #(.BIT_LEN(BL)) DUT (.clk(clk), .rst(rst), .link_enable(link_enable),
        .serial_rx_pin(line_to_dut), .serial_tx_pin_ff(tx_pin),
        .store_refused_ff(refused), .sender_busy_ff(busy));
    uar_remote_dev #(.BIT_LEN(BL)) far_end (.clk(clk), .line_in(tx_pin),
        .line_out(line_to_dut));
    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Compares one byte result.
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Queues one expected four character answer.
    task automatic push4(input logic [7:0] a, input logic [7:0] b);
        exp_q.push_back(a);
        exp_q.push_back(b);
        exp_q.push_back(8'h0D);
        exp_q.push_back(8'h0A);
    endtask
    // Counts refusals and cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (refused === 1'b1) refusals++;
        if (cycles == 80_000) begin
            bad_count++;
            test_done();
        end
    end
    // Main sequence.
    initial begin
        logic [7:0] d;
        void'($urandom(32'h3C5E));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        far_end.send(8'h54, 1'b0, 1'b0);
        link_enable <= 1'b1;
        @(posedge clk);
        far_end.send(8'h54, 1'b0, 1'b0);
        push4(8'h4F, 8'h4B);
        far_end.send(8'h74, 1'b0, 1'b0);
        push4(8'h6F, 8'h6B);
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom_range(255));
            if (d == 8'h54 || d == 8'h74) d = 8'h3F;
            far_end.send(d, 1'b0, 1'b0);
            push4(8'h55, 8'h43);
        end
        far_end.send(8'h54, 1'b1, 1'b0);
        push4(8'h50, 8'h45);
        far_end.send(8'h74, 1'b0, 1'b1);
        push4(8'h46, 8'h45);
        far_end.send(8'h41, 1'b1, 1'b1);
        push4(8'h50, 8'h45);
        push4(8'h46, 8'h45);
        while (far_end.got_q.size() < exp_q.size()) @(posedge clk);
        repeat (2 * 11 * BL) @(posedge clk);
        cmp_byte(8'(far_end.got_q.size()), 8'(exp_q.size()));
        foreach (exp_q[i]) cmp_byte(far_end.got_q[i], exp_q[i]);
        cmp_byte(8'(far_end.line_faults), 8'h00);
        cmp_byte(8'(refusals), 8'h00);
        repeat (28) far_end.send(8'h54, 1'b0, 1'b0);
        while (far_end.got_q.size() + 4 * refusals < exp_q.size() + 112) @(posedge clk);
        repeat (22 * BL) @(posedge clk);
        cmp_byte(8'(refusals != 0), 8'h01);
        repeat (28 - refusals) push4(8'h4F, 8'h4B);
        cmp_byte(8'(far_end.got_q.size()), 8'(exp_q.size()));
        foreach (exp_q[i]) cmp_byte(far_end.got_q[i], exp_q[i]);
        test_done();
    end
endmodule
